// ==== rtl/lps_pkg.sv ====
// Shared constants and types for the LED PWM serial/latch controller
package lps_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int LPS_CHANNELS = 16;   // Current sink outputs
    localparam int LPS_GS_BITS = 16;    // Grayscale bits per channel
    localparam int LPS_BC_BITS = 7;     // Brightness bits
    localparam int LPS_GS_LEN = 256;    // Grayscale/status shift register length
    localparam int LPS_BC_LEN = 7;      // Brightness shift register length
    localparam int LPS_FIFO_DEPTH = 16; // Serial bit FIFO depth
    // ----------------------------------------------------------------
    // Timing and reset values
    // ----------------------------------------------------------------
    localparam int LPS_SYNC_STAGES = 3;                 // Pin synchroniser depth
    localparam logic [15:0] LPS_GS_CNT_RST = 16'h0000;  // Counter value while blanked
    localparam logic [15:0] LPS_LOD_SAMPLE = 16'h0021;  // Edge count 33 samples open-LED
    // ----------------------------------------------------------------
    // Selector values
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        LPS_SEL_GS = 1'b0,  // Grayscale/status register chosen
        LPS_SEL_BC = 1'b1   // Brightness register chosen
    } lps_sel_e;
    // FIFO entry: one serial bit with its selector
    typedef struct packed {
        logic sel;
        logic bit_val;
    } lps_bit_s;
endpackage : lps_pkg

// ==== rtl/lps_stream_if.sv ====
// Valid/ready carrier between the pin front end and the bit FIFO
`timescale 1ns/1ps
interface lps_stream_if #(parameter int WIDTH = 2);
    logic valid;              // Source holds a word
    logic ready;              // Sink accepts a word
    logic [WIDTH-1:0] data;   // Word
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : lps_stream_if

// ==== rtl/lps_fifo.sv ====
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lps_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    lps_stream_if.snk wr,
    lps_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
    logic [AW-1:0] wp_q;              // Write index
    logic [AW-1:0] rp_q;              // Read index
    logic [AW:0] cnt_q;               // Occupancy
    logic push;
    logic pop;
    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem_q[rp_q];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    // ----------------------------------------------------------------
    // Storage write, no reset needed on data
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end
    // Pointers and count
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : lps_fifo

// ==== rtl/lps_ctrl.sv ====
// Top of the LED PWM serial input, latch and grayscale counter control
// Summary of operation
// R1: Shift clock rise captures input bit
// R2: Selected register shifts toward MSB
// R3: Serial output shows selected register MSB
// R4: Latch strobe rise copies into latch
// R5: Select low grayscale, high brightness
// R6: Host changes select only clock-low
// R7: Unblanked reference clock rise increments counter
// R8: Blank forces outputs off, counter zero
// R9: Unblanked outputs follow PWM compare while overtemp is low
// R10: Serial output source follows select
// R11: Fault pin low on open-LED or overtemp; the code counts open-LED only on channels whose sink output is on
// R12: Status loads on first clock after strobe
// R13: Open-LED status sampled at edge 33
// R14: Register lengths are parameters
`timescale 1ns/1ps
module lps_ctrl
    import lps_pkg::*;
#(
    parameter int GS_LEN = LPS_GS_LEN, // R14
    parameter int BC_LEN = LPS_BC_LEN
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic serial_in_i,
    input wire logic shift_clk_i,
    input wire logic latch_strobe_i,
    input wire logic register_select_i,
    input wire logic pwm_ref_clock_i,
    input wire logic blank_i,
    input wire logic [LPS_CHANNELS-1:0] open_led_detect_i,
    input wire logic overtemp_flag_i,
    output logic serial_out_o,
    output logic fault_out_n_o,
    output logic fault_out_n_oe_o,
    output logic [LPS_CHANNELS-1:0] current_sink_outputs_o,
    output logic [GS_LEN-1:0] grayscale_latch_o,
    output logic [BC_LEN-1:0] brightness_latch_o
);
    // ----------------------------------------------------------------
    // Pin synchronisers, three stages each
    // ----------------------------------------------------------------
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] s1_q;  // First stage, read only by s2
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] st_q;  // Filtered level, moves when s2 and s3 agree
    assign pins = {blank_i, pwm_ref_clock_i, register_select_i, latch_strobe_i, shift_clk_i, serial_in_i};
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            st_q <= {1'b1, {(NSYNC-1){1'b0}}};
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    st_q[i] <= s3_q[i];
                end
            end
        end
    end
    // Level aliases and edge detection on the filtered levels
    logic [NSYNC-1:0] prev_q;
    logic sin_l, sclk_rise, xl_rise, xl_fall, sel_l, gck_rise, blank_l;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_q <= {1'b1, {(NSYNC-1){1'b0}}};
        end else begin
            prev_q <= st_q;
        end
    end
    assign sin_l = st_q[0];
    assign sclk_rise = st_q[1] && !prev_q[1];
    assign xl_rise = st_q[2] && !prev_q[2];
    assign xl_fall = !st_q[2] && prev_q[2];
    assign sel_l = st_q[3];
    assign gck_rise = st_q[4] && !prev_q[4];
    assign blank_l = st_q[5];
    // ----------------------------------------------------------------
    // Captured bits pass through the FIFO to the shifters
    // ----------------------------------------------------------------
    // The select is sampled with the bit, so a select change right after a
    // clock rise cannot steer a bit still waiting in the FIFO.
    lps_stream_if #(.WIDTH(2)) fin ();
    lps_stream_if #(.WIDTH(2)) fout ();
    lps_bit_s in_bit;
    lps_bit_s out_bit;
    logic drop_q;  // Sticky: a bit was lost because the FIFO was full
    assign in_bit.sel = sel_l; // R5 R6
    assign in_bit.bit_val = sin_l;
    assign fin.valid = sclk_rise; // R1
    assign fin.data = in_bit;
    assign out_bit = lps_bit_s'(fout.data);
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drop_q <= 1'b0;
        end else if (sclk_rise && !fin.ready) begin
            drop_q <= 1'b1;
        end
    end
    lps_fifo #(.WIDTH(2), .DEPTH(LPS_FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .wr(fin),
        .rd(fout)
    );
    // Drain stalls only while a latch strobe rise copies the selected shifter into its latch
    logic stall;
    logic status_pend_q;  // Status load waits for the next shift clock rise
    assign stall = xl_rise;
    assign fout.ready = !stall;
    // ----------------------------------------------------------------
    // Shift registers, latches and status load
    // ----------------------------------------------------------------
    logic [GS_LEN-1:0] gs_sr_q;
    logic [BC_LEN-1:0] bc_sr_q;
    logic [LPS_CHANNELS-1:0] lod_saved_q;  // Open-LED result of the last period
    logic [LPS_CHANNELS-1:0] lod_rep_q;    // Copy taken at period end for readout
    logic tef_seen_q;                       // Overtemp since last readout
    logic pop_now;
    assign pop_now = fout.valid && fout.ready;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_pend_q <= 1'b0;
        end else if (xl_fall) begin
            status_pend_q <= 1'b1;
        end else if (pop_now) begin
            status_pend_q <= 1'b0;
        end
    end
    // Grayscale/status shifter
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gs_sr_q <= '0;
        end else if (pop_now && status_pend_q) begin
            gs_sr_q <= GS_LEN'({tef_seen_q, lod_rep_q}); // R12 R13
        end else if (pop_now && out_bit.sel == LPS_SEL_GS) begin
            gs_sr_q <= {gs_sr_q[GS_LEN-2:0], out_bit.bit_val}; // R1 R2
        end
    end
    // Brightness shifter
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bc_sr_q <= '0;
        end else if (pop_now && !status_pend_q && out_bit.sel == LPS_SEL_BC) begin
            // Cast keeps the low bits, so a one-bit register works as well
            bc_sr_q <= BC_LEN'({bc_sr_q, out_bit.bit_val}); // R1 R2
        end
    end
    // First data latches
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            grayscale_latch_o <= '0;
            brightness_latch_o <= '0;
        end else if (xl_rise) begin
            if (sel_l == LPS_SEL_BC) begin
                brightness_latch_o <= bc_sr_q; // R4 R5
            end else begin
                grayscale_latch_o <= gs_sr_q; // R4 R5
            end
        end
    end
    // Serial output follows selection
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_out_o <= 1'b0;
        end else begin
            serial_out_o <= (sel_l == LPS_SEL_BC) ? bc_sr_q[BC_LEN-1] : gs_sr_q[GS_LEN-1]; // R3 R10
        end
    end
    // ----------------------------------------------------------------
    // Grayscale counter and PWM compare
    // ----------------------------------------------------------------
    logic [15:0] gs_cnt_q;
    logic [15:0] gs_cnt_d;
    assign gs_cnt_d = gs_cnt_q + 16'h0001;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gs_cnt_q <= LPS_GS_CNT_RST;
        end else if (blank_l) begin
            gs_cnt_q <= LPS_GS_CNT_RST; // R8
        end else if (gck_rise) begin
            gs_cnt_q <= gs_cnt_d; // R7
        end
    end
    // Open-LED sample at the 33rd edge; handed to readout when the period ends,
    // by counter wrap or by blanking, so a blanked period is still reported
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lod_saved_q <= '0;
            lod_rep_q <= '0;
        end else if (blank_l) begin
            if (gs_cnt_q != LPS_GS_CNT_RST) begin
                lod_rep_q <= lod_saved_q; // R13
            end
        end else if (gck_rise) begin
            if (gs_cnt_d == LPS_LOD_SAMPLE) begin
                lod_saved_q <= open_led_detect_i; // R13
            end
            if (gs_cnt_d == 16'h0000) begin
                lod_rep_q <= lod_saved_q; // R13
            end
        end
    end
    // Overtemp sticky until readout; a new flag wins over the clear
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tef_seen_q <= 1'b0;
        end else if (overtemp_flag_i) begin
            tef_seen_q <= 1'b1;
        end else if (pop_now && status_pend_q) begin
            tef_seen_q <= 1'b0;
        end
    end
    // One generate loop compares each channel against its latched value
    for (genvar ch = 0; ch < LPS_CHANNELS; ch++) begin : g_pwm
        logic [15:0] gs_val;
        if ((ch + 1) * LPS_GS_BITS <= GS_LEN) begin : g_has
            assign gs_val = grayscale_latch_o[ch*LPS_GS_BITS +: LPS_GS_BITS]; // R14
        end else begin : g_none
            assign gs_val = 16'h0000;
        end
        always_ff @(posedge mclk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                current_sink_outputs_o[ch] <= 1'b0;
            end else if (blank_l || overtemp_flag_i) begin
                current_sink_outputs_o[ch] <= 1'b0; // R8
            end else begin
                current_sink_outputs_o[ch] <= (gs_cnt_q < gs_val); // R9
            end
        end
    end
    // ----------------------------------------------------------------
    // Open-drain fault pin
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_out_n_o <= 1'b0;
            fault_out_n_oe_o <= 1'b0;
        end else begin
            fault_out_n_o <= 1'b0;
            fault_out_n_oe_o <= (|(open_led_detect_i & current_sink_outputs_o)) || overtemp_flag_i; // R11
        end
    end
endmodule : lps_ctrl

// ==== testbench/lps_host_model.sv ====
// Host side model driving the serial port pins
`timescale 1ns/1ps
module lps_host_model (
    output logic serial_in_o,
    output logic shift_clk_o,
    output logic latch_strobe_o,
    output logic register_select_o
);
    // ----------------------------------------------------------------
    // Pin drivers, 48 ns link clock that stands low between frames
    // ----------------------------------------------------------------
    initial begin
        serial_in_o = 1'b0;
        shift_clk_o = 1'b0;
        latch_strobe_o = 1'b0;
        register_select_o = 1'b0;
    end
    // Shift n bits of v, most significant first
    task automatic send(input logic sel, input int n, input logic [31:0] v);
        register_select_o = sel;
        #24;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_o = v[i];
            #24 shift_clk_o = 1'b1;
            #24 shift_clk_o = 1'b0;
        end
        // Released data line must not keep the last bit
        serial_in_o = ~serial_in_o;
    endtask : send
    // One latch pulse, clock held low around it
    task automatic strobe();
        latch_strobe_o = 1'b1;
        #24 latch_strobe_o = 1'b0;
        #24;
    endtask : strobe
endmodule : lps_host_model

// ==== testbench/lps_ctrl_assertions.sv ====
// Port checker for the controller, bound into the top
`timescale 1ns/1ps
module lps_ctrl_checker
    import lps_pkg::*;
#(
    parameter int GS_LEN = LPS_GS_LEN,
    parameter int BC_LEN = LPS_BC_LEN
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic shift_clk_i,
    input wire logic latch_strobe_i,
    input wire logic register_select_i,
    input wire logic pwm_ref_clock_i,
    input wire logic blank_i,
    input wire logic [LPS_CHANNELS-1:0] open_led_detect_i,
    input wire logic overtemp_flag_i,
    input wire logic serial_out_o,
    input wire logic fault_out_n_o,
    input wire logic fault_out_n_oe_o,
    input wire logic [LPS_CHANNELS-1:0] current_sink_outputs_o,
    input wire logic [GS_LEN-1:0] grayscale_latch_o,
    input wire logic [BC_LEN-1:0] brightness_latch_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Eight cycles leave room for the pin synchronisers
    sequence s_port_quiet;
        (!shift_clk_i && $stable(register_select_i)) [*8];
    endsequence
    sequence s_pwm_quiet;
        (!pwm_ref_clock_i && !blank_i && !overtemp_flag_i && $stable(grayscale_latch_o)) [*8];
    endsequence
    AST_FAULT_DATA: assert property (fault_out_n_o == 1'b0)
        else $error("fault pin data not low");
    AST_TEMP_FAULT: assert property (overtemp_flag_i [*3] |=> fault_out_n_oe_o)
        else $error("fault pin not pulled on overtemp");
    AST_FAULT_CLEAR: assert property ((!overtemp_flag_i && open_led_detect_i == '0) [*4] |=> !fault_out_n_oe_o)
        else $error("fault pin pulled without cause");
    AST_BLANK_OFF: assert property (blank_i [*8] |=> current_sink_outputs_o == '0)
        else $error("sink on while blanked");
    AST_TEMP_OFF: assert property (overtemp_flag_i [*3] |=> current_sink_outputs_o == '0)
        else $error("sink on while hot");
    AST_LATCH_HOLD: assert property (!latch_strobe_i [*8] |=> $stable(grayscale_latch_o) && $stable(brightness_latch_o))
        else $error("latch moved without strobe");
    AST_SERIAL_OUT_HOLD: assert property (s_port_quiet |=> $stable(serial_out_o))
        else $error("serial out moved without shift");
    AST_PWM_HOLD: assert property (s_pwm_quiet |=> $stable(current_sink_outputs_o))
        else $error("sink moved without reference edge");
endmodule : lps_ctrl_checker
bind lps_ctrl lps_ctrl_checker #(.GS_LEN(GS_LEN), .BC_LEN(BC_LEN)) chk_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .shift_clk_i(shift_clk_i), .latch_strobe_i(latch_strobe_i), .register_select_i(register_select_i),
    .pwm_ref_clock_i(pwm_ref_clock_i), .blank_i(blank_i), .open_led_detect_i(open_led_detect_i),
    .overtemp_flag_i(overtemp_flag_i), .serial_out_o(serial_out_o), .fault_out_n_o(fault_out_n_o),
    .fault_out_n_oe_o(fault_out_n_oe_o), .current_sink_outputs_o(current_sink_outputs_o),
    .grayscale_latch_o(grayscale_latch_o), .brightness_latch_o(brightness_latch_o));

// ==== testbench/tb.sv ====
// Self-checking bench for the serial, latch and PWM controller
`timescale 1ns/1ps
module tb;
    import lps_pkg::*;
    localparam int GL = 32; // Short grayscale register keeps frames brief
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic serial_in, sclk, stb, sel, serial_out, f_n, f_oe;
    logic pwm = 1'b0;
    logic blank = 1'b1;
    logic hot = 1'b0;
    logic [15:0] open_led = 16'h0000;
    logic [15:0] sink;
    logic [GL-1:0] gs_l, sh_gs, lat_gs, d;
    logic [6:0] bc_l, sh_bc, lat_bc;
    logic armed, cur_sel, tef_m;
    logic [15:0] lod_m, lod_samp; // Reported and sampled open-LED flags
    int fails = 0;
    int comparisons = 0;
    int seed = 32'h1ca0;
    lps_host_model host_inst (.serial_in_o(serial_in), .shift_clk_o(sclk), .latch_strobe_o(stb), .register_select_o(sel));
    lps_ctrl #(.GS_LEN(GL), .BC_LEN(LPS_BC_LEN)) lps_ctrl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .serial_in_i(serial_in), .shift_clk_i(sclk), .latch_strobe_i(stb), .register_select_i(sel),
        .pwm_ref_clock_i(pwm), .blank_i(blank), .open_led_detect_i(open_led), .overtemp_flag_i(hot),
        .serial_out_o(serial_out), .fault_out_n_o(f_n), .fault_out_n_oe_o(f_oe), .current_sink_outputs_o(sink),
        .grayscale_latch_o(gs_l), .brightness_latch_o(bc_l));
    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    // Whole run needs some 10 us; a hang counts as a mismatch
    initial begin
        #100000;
        fails++;
        results();
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // Shift a frame through the host and the model alike
    task automatic frame(input logic s, input int n, input logic [31:0] v);
        @(negedge mclk_i);
        cur_sel = s;
        host_inst.send(s, n, v);
        for (int i = n - 1; i >= 0; i--) begin
            if (s) sh_bc = {sh_bc[5:0], v[i]};
            else if (armed) sh_gs = GL'({tef_m, lod_m});
            else sh_gs = {sh_gs[GL-2:0], v[i]};
            if (!s && armed) tef_m = 1'b0;
            if (!s) armed = 1'b0;
        end
        repeat (10) @(negedge mclk_i);
        check(serial_out, s ? sh_bc[6] : sh_gs[GL-1]);
    endtask : frame
    // Strobe, then only the chosen latch takes its shifter
    task automatic latch();
        host_inst.strobe();
        armed = 1'b1;
        if (cur_sel) lat_bc = sh_bc;
        else lat_gs = sh_gs;
        repeat (10) @(negedge mclk_i);
        check(gs_l, lat_gs);
        check(bc_l, lat_bc);
    endtask : latch
    task automatic pulse();
        pwm = 1'b1;
        repeat (5) @(negedge mclk_i);
        pwm = 1'b0;
        repeat (10) @(negedge mclk_i);
    endtask : pulse
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {sh_gs, lat_gs, sh_bc, lat_bc, armed, cur_sel, tef_m, lod_m, lod_samp} = '0;
        repeat (10) @(negedge mclk_i);
        rstn_i = 1'b1;
        frame(1, 7, $random(seed));
        latch();
        // Leading spare bit soaks up a pending status load
        frame(0, 1, 1);
        frame(0, GL, $random(seed));
        latch();
        frame(0, 1, 1);
        latch();
        d = $random(seed) & 32'h001f001f;
        frame(0, 1, 1);
        frame(0, GL, d);
        latch();
        frame(1, 0, 0);
        check(sink, 0);
        blank = 1'b0;
        for (int k = 0; k < 36; k++) begin
            repeat (10) @(negedge mclk_i);
            check(sink, {k < d[31:16], k < d[15:0]});
            open_led = $random(seed);
            if (k == 32) lod_samp = open_led;
            pulse();
        end
        // Edges under blank must leave the counter at zero
        blank = 1'b1;
        lod_m = lod_samp;
        pulse();
        pulse();
        check(sink, 0);
        blank = 1'b0;
        repeat (10) @(negedge mclk_i);
        check(sink, {d[31:16] != 0, d[15:0] != 0});
        hot = 1'b1;
        tef_m = 1'b1;
        repeat (10) @(negedge mclk_i);
        check(f_oe, 1);
        check(sink, 0);
        hot = 1'b0;
        open_led = 16'h0000;
        repeat (10) @(negedge mclk_i);
        check(f_oe, 0);
        check(f_n, 0);
        // Status readout: overtemp seen and the open-LED flags of edge 33
        frame(0, 1, 0);
        latch();
        check(gs_l, {15'h0000, 1'b1, lod_samp});
        results();
    end
endmodule : tb
